// ===== psq_pkg.sv
// Package for the program sequencer and call stack
package psq_pkg;
    localparam int ADDR_W = 12;
    localparam int LOW_W = 8;
    localparam int HIGH_W = 4;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 12'h000;
    localparam logic RESET_DEPTH = 1'b0;
    localparam logic [1:0] PAGE0 = 2'h0;
    localparam logic [4:0] LAST_WORD = 5'h1f;
    localparam logic [1:0] MAX_LEN = 2'h2;
    typedef enum logic [2:0] {
        PSQ_RUN = 3'b001,
        PSQ_FAULT = 3'b010,
        PSQ_RESTART = 3'b100
    } psq_state_type;
endpackage : psq_pkg

// ===== psq_shared_word.sv
// Return address storage whose low byte is the page0 last data word
`timescale 1ns/10ps
module psq_shared_word
    import psq_pkg::*;
(
    input wire logic clk,
    input wire logic save,
    input wire logic [ADDR_W-1:0] save_addr,
    input wire logic ram_write,
    input wire logic ram_sel,
    input wire logic [LOW_W-1:0] ram_wdata,
    output logic [ADDR_W-1:0] stored
);
    // ************************************************
    // No reset: contents survive a reset
    // ************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
    } psq_word_type;
    psq_word_type r;
    psq_word_type next_r;

    always_comb begin
        next_r = r;
        if (save) begin
            next_r.addr = save_addr;
        end else if (ram_write && ram_sel) begin
            next_r.addr[LOW_W-1:0] = ram_wdata;
            next_r.addr[ADDR_W-1:LOW_W] = {HIGH_W{1'b0}};
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    assign stored = r.addr;
endmodule : psq_shared_word

// ===== psq_sequencer.sv
// Program sequencer with single level call stack and fault reset
// ************************************************
// ************************************************
`timescale 1ns/10ps
module psq_sequencer
    import psq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic step,
    input wire logic [1:0] instr_len,
    input wire logic jump_taken,
    input wire logic call,
    input wire logic subroutine_exit,
    input wire logic [ADDR_W-1:0] operand_addr,
    input wire logic ram_write,
    input wire logic [1:0] ram_page,
    input wire logic [4:0] ram_addr,
    input wire logic [LOW_W-1:0] ram_wdata,
    output logic [ADDR_W-1:0] next_instr_addr,
    output logic stack_depth_bit,
    output logic [ADDR_W-1:0] return_addr_reg,
    output logic [LOW_W-1:0] page0_last_word,
    output logic system_reset
);
    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        psq_state_type state;
        logic [ADDR_W-1:0] pc;
        logic depth;
        logic sys_rst;
        logic [ADDR_W-1:0] ret_copy;
    } psq_seq_type;
    psq_seq_type r;
    psq_seq_type next_r;
    logic [ADDR_W-1:0] stored;
    logic save;
    logic ram_sel;
    logic fault;

    assign ram_sel = (ram_page == PAGE0) && (ram_addr == LAST_WORD);
    assign save = step && call && (r.state == PSQ_RUN) && !fault;
    // Call at depth 1 or return at depth 0 faults the core and pulses system_reset
    // Only a running core can fault; steps while restarting are dropped
    assign fault = step && (r.state == PSQ_RUN)
        && ((call && r.depth) || (subroutine_exit && !r.depth));

    psq_shared_word u_word (
        .clk(clk),
        .save(save),
        .save_addr(r.pc),
        .ram_write(ram_write),
        .ram_sel(ram_sel),
        .ram_wdata(ram_wdata),
        .stored(stored)
    );

    // Call with exit always faults, call or exit outranks jump, jump outranks advance
    always_comb begin
        next_r = r;
        // Visible copy lags storage by one cycle so the output is a flop
        next_r.ret_copy = stored;
        next_r.sys_rst = 1'b0;
        case (r.state)
            PSQ_RUN: begin
                if (fault) begin
                    next_r.state = PSQ_FAULT;
                    next_r.sys_rst = 1'b1;
                    next_r.pc = RESET_ADDR;
                    next_r.depth = RESET_DEPTH;
                end else if (step) begin
                    if (call) begin
                        next_r.pc = operand_addr;
                        next_r.depth = 1'b1;
                    end else if (subroutine_exit) begin
                        next_r.pc = stored;
                        next_r.depth = 1'b0;
                    end else if (jump_taken) begin
                        next_r.pc = operand_addr;
                    end else begin
                        next_r.pc = r.pc + ADDR_W'(instr_len);
                    end
                end
            end
            // Two dead cycles let the rest of the core see the pulse
            PSQ_FAULT: begin
                next_r.state = PSQ_RESTART;
            end
            PSQ_RESTART: begin
                next_r.state = PSQ_RUN;
            end
            default: begin
                next_r.state = PSQ_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r.state <= PSQ_RUN;
            r.pc <= RESET_ADDR;
            r.depth <= RESET_DEPTH;
            r.sys_rst <= 1'b0;
            r.ret_copy <= next_r.ret_copy;
        end else begin
            r <= next_r;
        end
    end

    assign next_instr_addr = r.pc;
    assign stack_depth_bit = r.depth;
    assign return_addr_reg = r.ret_copy;
    assign page0_last_word = r.ret_copy[LOW_W-1:0];
    assign system_reset = r.sys_rst;

    // ************************************************
    // Checks
    // ************************************************
    chk_fault_pc: assert property (@(posedge clk) disable iff (reset)
        fault |=> (system_reset && next_instr_addr == RESET_ADDR && !stack_depth_bit))
        else $error("fault did not reset sequencer");
    chk_call_load: assert property (@(posedge clk) disable iff (reset)
        save |=> (next_instr_addr == $past(operand_addr) && stack_depth_bit))
        else $error("call did not load destination");
    chk_call_save: assert property (@(posedge clk) disable iff (reset)
        save |=> ##1 (return_addr_reg == $past(next_instr_addr, 2)))
        else $error("call did not save return address");
    chk_ret_restore: assert property (@(posedge clk) disable iff (reset)
        (step && subroutine_exit && r.depth && r.state == PSQ_RUN)
        |=> (next_instr_addr == $past(stored) && !stack_depth_bit))
        else $error("return did not restore counter");
    chk_seq_step: assert property (@(posedge clk) disable iff (reset)
        (r.state == PSQ_RUN && step && !call && !subroutine_exit && !jump_taken)
        |=> next_instr_addr == $past(next_instr_addr) + ADDR_W'($past(instr_len)))
        else $error("counter did not advance by length");
    chk_jump_load: assert property (@(posedge clk) disable iff (reset)
        (r.state == PSQ_RUN && step && jump_taken && !call && !subroutine_exit)
        |=> next_instr_addr == $past(operand_addr))
        else $error("jump did not load destination");
    chk_depth_hold: assert property (@(posedge clk) disable iff (reset)
        (!step) |=> $stable(stack_depth_bit))
        else $error("depth changed without call or return");
    chk_reset_pc: assert property (@(posedge clk)
        reset |=> (next_instr_addr == RESET_ADDR && !stack_depth_bit))
        else $error("reset did not clear counter");
    chk_ret_keep: assert property (@(posedge clk) disable iff (reset)
        (step && subroutine_exit && r.depth && r.state == PSQ_RUN && !ram_write)
        |=> ##1 $stable(return_addr_reg))
        else $error("return cleared saved address");

    // ************************************************
    // Fault recovery and shared word checks
    // ************************************************
    // Fault pulse lasts exactly one cycle
    chk_fault_pulse: assert property (@(posedge clk) disable iff (reset)
        system_reset |=> !system_reset)
        else $error("system reset pulse too long");

    // Core is back in service two cycles after the pulse
    chk_restart_run: assert property (@(posedge clk) disable iff (reset)
        system_reset |=> ##1 (r.state == PSQ_RUN))
        else $error("sequencer did not resume after fault");

    // Steps during recovery must not move the counter
    chk_refuse_pc: assert property (@(posedge clk) disable iff (reset)
        (r.state != PSQ_RUN) |=> $stable(next_instr_addr))
        else $error("counter moved during fault recovery");

    // Nor the depth bit
    chk_refuse_depth: assert property (@(posedge clk) disable iff (reset)
        (r.state != PSQ_RUN) |=> $stable(stack_depth_bit))
        else $error("depth moved during fault recovery");

    // Idle cycles hold the counter
    chk_idle_pc: assert property (@(posedge clk) disable iff (reset)
        (!step && r.state == PSQ_RUN) |=> $stable(next_instr_addr))
        else $error("counter moved without a step");

    // A faulting call must not overwrite the saved address
    chk_fault_keep: assert property (@(posedge clk) disable iff (reset)
        (fault && call && !ram_write) |=> ##1 $stable(return_addr_reg))
        else $error("faulting call changed saved address");

    // Data write to the shared word lands in the low byte
    chk_ram_low: assert property (@(posedge clk) disable iff (reset)
        (ram_write && ram_sel && !save)
        |=> ##1 (page0_last_word == $past(ram_wdata, 2)))
        else $error("shared word write lost");

    // Upper nibble reads zero after a data access
    chk_ram_high: assert property (@(posedge clk) disable iff (reset)
        (ram_write && ram_sel && !save)
        |=> ##1 (return_addr_reg[ADDR_W-1:LOW_W] == {HIGH_W{1'b0}}))
        else $error("upper nibble not cleared");

    // Writes to any other word leave the saved address alone
    chk_ram_other: assert property (@(posedge clk) disable iff (reset)
        (ram_write && !ram_sel && !save) |=> ##1 $stable(return_addr_reg))
        else $error("other data word changed saved address");
endmodule : psq_sequencer

// ===== psq_sequencer_tb.sv
// Self-checking bench for the program sequencer
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module psq_sequencer_tb import psq_pkg::*;;
    logic clk = 0, reset = 1, step = 0, jump_taken = 0, call = 0, subroutine_exit = 0;
    logic ram_write = 0, stack_depth_bit, system_reset, depth_m, step_d = 0;
    logic [1:0] instr_len = 2'h0, ram_page = 2'h0;
    logic [4:0] ram_addr = 5'h00;
    logic [7:0] ram_wdata = 8'h00, page0_last_word, d;
    logic [11:0] operand_addr = 12'h000, next_instr_addr, return_addr_reg, pc_m, saved_m;
    logic [13:0] expq[$];
    int err_total = 0, checks = 0;
    psq_sequencer psq_sequencer_inst (.clk(clk), .reset(reset), .step(step),
        .instr_len(instr_len), .jump_taken(jump_taken), .call(call),
        .subroutine_exit(subroutine_exit), .operand_addr(operand_addr),
        .ram_write(ram_write), .ram_page(ram_page), .ram_addr(ram_addr),
        .ram_wdata(ram_wdata), .next_instr_addr(next_instr_addr),
        .stack_depth_bit(stack_depth_bit), .return_addr_reg(return_addr_reg),
        .page0_last_word(page0_last_word), .system_reset(system_reset));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) step_d <= step & ~reset;
    // Outputs settle after the taking edge, so compare at the falling edge
    always @(negedge clk) if (step_d) `CHK({system_reset, stack_depth_bit, next_instr_addr}, expq.pop_front())
    task automatic op(input logic c, e, j, input logic [1:0] len, input logic [11:0] a);
        logic f;
        @(posedge clk);
        step <= 1'b1;
        call <= c;
        subroutine_exit <= e;
        jump_taken <= j;
        instr_len <= len;
        operand_addr <= a;
        f = (c && depth_m) || (!c && e && !depth_m);
        if (f) pc_m = 12'h000;
        else if (c) begin
            saved_m = pc_m;
            pc_m = a;
        end else if (e) pc_m = saved_m;
        else if (j) pc_m = a;
        else pc_m = pc_m + 12'(len);
        depth_m = f ? 1'b0 : (c ? 1'b1 : (e ? 1'b0 : depth_m));
        expq.push_back({f, depth_m, pc_m});
    endtask : op
    task automatic idle(input int n);
        @(posedge clk);
        step <= 1'b0;
        ram_write <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic wr(input logic [1:0] pg, input logic [7:0] v);
        @(posedge clk);
        step <= 1'b0;
        ram_write <= 1'b1;
        ram_page <= pg;
        ram_addr <= 5'h1f;
        ram_wdata <= v;
        idle(2);
    endtask : wr
    task automatic summarize;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    initial begin
        #20000;
        err_total++;
        summarize();
    end
    initial begin
        void'($urandom(45876));
        pc_m = 12'h000;
        depth_m = 1'b0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        idle(1);
        `CHK({stack_depth_bit, next_instr_addr}, 13'h0000)
        for (int i = 0; i < 30; i++) op(0, 0, 1'($urandom), 2'($urandom_range(1, 2)), 12'($urandom));
        op(1, 0, 0, 2'h1, 12'h5a3);
        op(0, 1, 0, 2'h1, 12'h000);
        idle(2);
        `CHK({return_addr_reg, page0_last_word}, {saved_m, saved_m[7:0]})
        op(0, 1, 0, 2'h1, 12'h000);
        idle(3);
        op(1, 0, 0, 2'h2, 12'($urandom));
        op(1, 0, 0, 2'h1, 12'h111);
        idle(3);
        op(1, 0, 0, 2'h1, 12'h0c4);
        d = 8'($urandom);
        wr(2'h1, ~d);
        `CHK(return_addr_reg, saved_m)
        wr(2'h0, d);
        saved_m = {4'h0, d};
        `CHK({return_addr_reg, page0_last_word}, {saved_m, d})
        op(0, 1, 0, 2'h1, 12'h000);
        idle(2);
        @(posedge clk);
        reset <= 1'b1;
        idle(2);
        reset <= 1'b0;
        pc_m = 12'h000;
        depth_m = 1'b0;
        idle(1);
        `CHK({stack_depth_bit, next_instr_addr, return_addr_reg}, {1'b0, pc_m, saved_m})
        op(0, 1, 0, 2'h1, 12'h000);
        idle(3);
        summarize();
    end
endmodule : psq_sequencer_tb
